// >>> rtl/llps_cfg.svh
`ifndef LLPS_CFG_SVH
`define LLPS_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define LLPS_CLK_MHZ          25
`define LLPS_PEN_PULSE_US     15
`define LLPS_PEN_PULSE_CYC    (`LLPS_PEN_PULSE_US * `LLPS_CLK_MHZ)
`define LLPS_SCAN_DWELL_US    100
`define LLPS_SCAN_DWELL_CYC   (`LLPS_SCAN_DWELL_US * `LLPS_CLK_MHZ)
`define LLPS_SCAN_COLS        13

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LLPS_CTRL_OFS         8'h00
`define LLPS_STAT_OFS         8'h04
`define LLPS_EVT_OFS          8'h08
`define LLPS_RESULT_OFS       8'h0c

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define LLPS_CTRL_FOLLOWER    0
`define LLPS_CTRL_PEN_CLEAR   1
`define LLPS_CTRL_ANSWER      2
`define LLPS_CTRL_BUSY        3
`define LLPS_CTRL_TRIG        4
`define LLPS_CTRL_SCAN        5
`define LLPS_CTRL_RST         5'h08

// ----------------------------------------
// Event bits (write one to clear)
// ----------------------------------------
`define LLPS_EV_BUTTON        0
`define LLPS_EV_TRIG          1
`define LLPS_EV_FRESET        2
`define LLPS_EV_FTRIG         3
`define LLPS_EV_SCAN          4

// ----------------------------------------
// Synchroniser bit positions, idle levels
// ----------------------------------------
`define LLPS_S_SER            0
`define LLPS_S_TRIG_N         1
`define LLPS_S_RDY            2
`define LLPS_S_SENSE_N        3
`define LLPS_S_CLR_N          4
`define LLPS_S_PULSE_N        5
`define LLPS_S_BUTTON_N       6
`define LLPS_S_EXT_N          7
`define LLPS_SYNC_IDLE        8'hfb

`endif

// >>> rtl/llps_pkg.sv
package llps_pkg;
  typedef logic [7:0]  llps_addr_t;
  typedef logic [31:0] llps_data_t;
  typedef enum logic [1:0] {SCAN_IDLE, SCAN_CLEAR, SCAN_DWELL, SCAN_SAMPLE} llps_scan_e;
endpackage : llps_pkg

// >>> rtl/llps_if.sv
`timescale 1ns/10ps
`default_nettype none
// Loop between a unit and its neighbour; open-collector lines resolved here
interface llps_if;
  logic unit_loop_serial_out;
  logic peer_loop_serial_out;
  logic unit_trig_o;
  logic unit_trig_oe;
  logic unit_rdy_o;
  logic unit_rdy_oe;
  logic unit_sense_o;
  logic unit_sense_oe;
  logic unit_clr_o;
  logic unit_clr_oe;
  logic peer_rdy_o;
  logic peer_rdy_oe;
  logic peer_clr_o;
  logic peer_clr_oe;
  logic pen_light_pulse_n;
  logic loop_trig_n;
  logic loop_all_ready;
  logic loop_pen_sense_n;
  logic loop_pen_sense_clear_n;

  // A driver pulls its line low only while its enable is high
  assign loop_trig_n            = ~unit_trig_oe | unit_trig_o;
  assign loop_all_ready         = (~unit_rdy_oe | unit_rdy_o) & (~peer_rdy_oe | peer_rdy_o);
  assign loop_pen_sense_n       = ~unit_sense_oe | unit_sense_o;
  assign loop_pen_sense_clear_n = (~unit_clr_oe | unit_clr_o) & (~peer_clr_oe | peer_clr_o);

  modport unit (
    output unit_loop_serial_out, unit_trig_o, unit_trig_oe, unit_rdy_o, unit_rdy_oe,
    output unit_sense_o, unit_sense_oe, unit_clr_o, unit_clr_oe,
    input  peer_loop_serial_out, pen_light_pulse_n, loop_trig_n, loop_all_ready,
    input  loop_pen_sense_n, loop_pen_sense_clear_n
  );
  modport peer (
    output peer_loop_serial_out, peer_rdy_o, peer_rdy_oe, peer_clr_o, peer_clr_oe,
    output pen_light_pulse_n,
    input  unit_loop_serial_out, loop_trig_n, loop_all_ready, loop_pen_sense_n,
    input  loop_pen_sense_clear_n
  );
endinterface : llps_if
`default_nettype wire

// >>> rtl/llps_peer.sv
`timescale 1ns/10ps
`default_nettype none
`include "llps_cfg.svh"
// Neighbour follower unit together with the light pen
module llps_peer (
  input  wire logic CORE_CLK_IN,
  input  wire logic SRST_IN,
  llps_if.peer      LNK,
  input  wire logic PEN_FLASH_IN,
  input  wire logic PEN_CLEAR_IN,
  input  wire logic BUSY_IN,
  input  wire logic ANSWER_IN,
  input  wire logic TX_DATA_IN,
  output logic      RX_DATA_OUT,
  output logic      FOLLOW_RESET_OUT,
  output logic      FOLLOW_TRIG_OUT,
  output logic      PEN_SENSE_N_OUT,
  output logic      ALL_READY_OUT
);
  import llps_pkg::*;

  logic [3:0]  s1_q;
  logic [3:0]  s2_q;
  logic        trig_prev_q;
  logic [11:0] pulse_cnt_q;
  logic        pulse_n_q;
  logic        ser_q;
  logic        rdy_oe_q;
  logic        clr_oe_q;
  logic        oc_low_q;
  logic        trig_fall;

  // ----------------------------------------
  // Loop inputs
  // ----------------------------------------
  // Two flops before any logic looks at a loop line
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      s1_q        <= 4'hb;
      s2_q        <= 4'hb;
      trig_prev_q <= 1'b1;
    end
    else
    begin
      s1_q        <= {LNK.loop_pen_sense_n, LNK.loop_all_ready, LNK.loop_trig_n, LNK.unit_loop_serial_out};
      s2_q        <= s1_q;
      trig_prev_q <= s2_q[1];
    end
  end

  assign trig_fall = trig_prev_q & ~s2_q[1];

  // Trigger meaning decided by the ready line at the edge
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      FOLLOW_RESET_OUT <= 1'b0;
      FOLLOW_TRIG_OUT  <= 1'b0;
      PEN_SENSE_N_OUT  <= 1'b1;
      ALL_READY_OUT    <= 1'b0;
      RX_DATA_OUT      <= 1'b1;
    end
    else
    begin
      FOLLOW_RESET_OUT <= trig_fall & ~s2_q[2]; // RL19
      FOLLOW_TRIG_OUT  <= trig_fall & s2_q[2];  // RL20
      PEN_SENSE_N_OUT  <= s2_q[3];              // RL9
      ALL_READY_OUT    <= s2_q[2];
      RX_DATA_OUT      <= s2_q[0];
    end
  end

  // ----------------------------------------
  // Pen and loop drivers
  // ----------------------------------------
  // Fixed-width low pulse per flash; a flash during a pulse is ignored
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      pulse_cnt_q <= 12'h000;
      pulse_n_q   <= 1'b1;
    end
    else if (pulse_cnt_q != 12'h000)
    begin
      pulse_cnt_q <= pulse_cnt_q - 12'h001;
      pulse_n_q   <= (pulse_cnt_q == 12'h001); // RL1
    end
    else if (PEN_FLASH_IN)
    begin
      pulse_cnt_q <= 12'(`LLPS_PEN_PULSE_CYC);
      pulse_n_q   <= 1'b0;                     // RL1
    end
  end

  // Follower forwards unless answering the lead
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      ser_q    <= 1'b1;
      rdy_oe_q <= 1'b1;
      clr_oe_q <= 1'b0;
      oc_low_q <= 1'b0;
    end
    else
    begin
      ser_q    <= (TX_DATA_IN & ANSWER_IN) | (s2_q[0] & ~ANSWER_IN); // RL10
      rdy_oe_q <= BUSY_IN;      // RL17
      clr_oe_q <= PEN_CLEAR_IN; // RL9
      oc_low_q <= 1'b0;
    end
  end

  assign LNK.peer_loop_serial_out = ser_q;
  assign LNK.pen_light_pulse_n    = pulse_n_q;
  assign LNK.peer_rdy_o           = oc_low_q;
  assign LNK.peer_rdy_oe          = rdy_oe_q;
  assign LNK.peer_clr_o           = oc_low_q;
  assign LNK.peer_clr_oe          = clr_oe_q;
endmodule : llps_peer
`default_nettype wire

// >>> rtl/llps_unit.sv
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "llps_cfg.svh"
// Notes on behaviour
// RL1 - Pen gives about 15 us low pulse
// RL2 - Pulse rising edge sets flag, read low
// RL3 - Lead reads own flag, drives loop line
// RL4 - Follower reads pen sense from loop
// RL5 - Clear resets flag, also drives loop clear
// RL6 - Pen button falling edge raises interrupt
// RL7 - Button suspends refresh, scan takes display
// RL8 - Scan columns, clear before each, sample
// RL9 - No lead hit: followers scan, watch lead
// RL10 - Serial out feeds next; control lines bused
// RL11 - Lead and standalone assert transmit gate
// RL12 - Follower gate closed except when answering
// RL13 - Incoming serial forwarded onto serial out
// RL14 - Forwarding enabled only while gate closed
// RL15 - Follower triggers from loop, never drives it
// RL16 - Lead triggers from external input, drives loop
// RL17 - Ready line low while any unit busy
// RL18 - Wait for all units ready after power-up
// RL19 - Trigger while not ready resets followers
// RL20 - Trigger while ready triggers followers
// RL21 - Open-collector outputs, buffered loop inputs
module llps_unit (
  input  wire logic              CORE_CLK_IN,
  input  wire logic              SRST_IN,
  llps_if.unit                   LNK,
  input  wire logic              PSEL_IN,
  input  wire logic              PENABLE_IN,
  input  wire logic              PWRITE_IN,
  input  wire llps_pkg::llps_addr_t PADDR_IN,
  input  wire llps_pkg::llps_data_t PWDATA_IN,
  output llps_pkg::llps_data_t   PRDATA_OUT,
  output logic                   PREADY_OUT,
  output logic                   PSLVERR_OUT,
  input  wire logic              PEN_BUTTON_N_IN,
  input  wire logic              EXT_TRIG_N_IN,
  input  wire logic              SER_TX_DATA_IN,
  output logic                   SER_RX_DATA_OUT,
  output logic                   SER_RTS_N_OUT,
  output logic                   PEN_SENSE_N_OUT,
  output logic                   IRQ_OUT,
  output logic                   DISP_SUSPEND_OUT,
  output logic                   DISP_COL_EN_OUT,
  output logic [3:0]             DISP_COL_OUT
);
  import llps_pkg::*;

  logic [7:0]  s1_q;
  logic [7:0]  s2_q;
  logic [7:0]  s3_q;
  logic [4:0]  ctrl_q;
  logic [4:0]  ev_q;
  logic [4:0]  ev_set;
  logic        flag_q;
  logic        sense_n_q;
  logic        loop_up_q;
  logic        ser_q;
  logic        rts_n_q;
  logic        trig_oe_q;
  logic        rdy_oe_q;
  logic        sense_oe_q;
  logic        clr_oe_q;
  logic        oc_low_q;
  logic        pready_q;
  logic        pslverr_q;
  llps_data_t  prdata_q;
  llps_scan_e  state_q;
  logic [3:0]  col_q;
  logic [11:0] dwell_q;
  logic        scan_clr_q;
  logic        col_en_q;
  logic        hit_q;
  logic [3:0]  hit_col_q;
  logic        follower;
  logic        wr_en;
  logic        wr_ctrl;
  logic        pen_rise;
  logic        button_fall;
  logic        loop_trig_fall;
  logic        trig_fall;
  logic        freset;
  logic        ftrig;
  logic        scan_go;
  logic        scan_done;

  // ----------------------------------------
  // Loop and pin inputs
  // ----------------------------------------
  // Buffered receive, two flops, third stage only for edges
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      s1_q <= `LLPS_SYNC_IDLE;
      s2_q <= `LLPS_SYNC_IDLE;
      s3_q <= `LLPS_SYNC_IDLE;
    end
    else
    begin
      s1_q <= {EXT_TRIG_N_IN, PEN_BUTTON_N_IN, LNK.pen_light_pulse_n, LNK.loop_pen_sense_clear_n,
               LNK.loop_pen_sense_n, LNK.loop_all_ready, LNK.loop_trig_n, LNK.peer_loop_serial_out}; // RL21
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge detects and decoded strobes
  assign follower       = ctrl_q[`LLPS_CTRL_FOLLOWER];
  assign pen_rise       = ~s3_q[`LLPS_S_PULSE_N] & s2_q[`LLPS_S_PULSE_N];  // RL2
  assign button_fall    = s3_q[`LLPS_S_BUTTON_N] & ~s2_q[`LLPS_S_BUTTON_N]; // RL6
  assign loop_trig_fall = s3_q[`LLPS_S_TRIG_N] & ~s2_q[`LLPS_S_TRIG_N];
  assign trig_fall      = follower ? loop_trig_fall
                                   : (s3_q[`LLPS_S_EXT_N] & ~s2_q[`LLPS_S_EXT_N]); // RL15 RL16
  assign freset         = follower & loop_trig_fall & ~s2_q[`LLPS_S_RDY];  // RL19
  assign ftrig          = follower & loop_trig_fall & s2_q[`LLPS_S_RDY];   // RL20
  assign wr_en          = PSEL_IN & PENABLE_IN & PWRITE_IN & pready_q;
  assign wr_ctrl        = wr_en & (PADDR_IN == `LLPS_CTRL_OFS);
  assign scan_go        = loop_up_q & (state_q == SCAN_IDLE)
                          & (button_fall | (wr_ctrl & PWDATA_IN[`LLPS_CTRL_SCAN])); // RL7 RL18
  assign scan_done      = (state_q == SCAN_SAMPLE) & (col_q == 4'(`LLPS_SCAN_COLS - 1));
  assign ev_set         = {scan_done, ftrig, freset, trig_fall, button_fall};

  // ----------------------------------------
  // Control and event registers
  // ----------------------------------------
  // A follower reset drops any pending answer
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      ctrl_q <= `LLPS_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= PWDATA_IN[4:0];
    else if (freset)
      ctrl_q[`LLPS_CTRL_ANSWER] <= 1'b0; // RL19
  end

  // Sticky events; a new event wins over its own clear
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      ev_q <= 5'h00;
    else if (wr_en && PADDR_IN == `LLPS_EVT_OFS)
      ev_q <= (ev_q & ~PWDATA_IN[4:0]) | ev_set;
    else
      ev_q <= ev_q | ev_set;
  end

  // Loop counts as up once every unit has shown ready
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      loop_up_q <= 1'b0;
    else if (s2_q[`LLPS_S_RDY])
      loop_up_q <= 1'b1; // RL18
  end

  // ----------------------------------------
  // Pen sense flag
  // ----------------------------------------
  // Set beats clear so a hit near a clear is kept
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      flag_q <= 1'b0;
    else if (pen_rise)
      flag_q <= 1'b1; // RL2
    else if (ctrl_q[`LLPS_CTRL_PEN_CLEAR] || scan_clr_q || !s2_q[`LLPS_S_CLR_N] || freset)
      flag_q <= 1'b0; // RL5 RL8
  end

  // Processor view of pen sense, active low
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      sense_n_q <= 1'b1;
    else
      sense_n_q <= follower ? s2_q[`LLPS_S_SENSE_N] : ~flag_q; // RL3 RL4 RL9
  end

  // ----------------------------------------
  // Column scan
  // ----------------------------------------
  // Dwell is long against the pen pulse so a hit lands inside it
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN || freset)
    begin
      state_q    <= SCAN_IDLE;
      col_q      <= 4'h0;
      dwell_q    <= 12'h000;
      scan_clr_q <= 1'b0;
      col_en_q   <= 1'b0;
      hit_q      <= 1'b0;
      hit_col_q  <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        SCAN_IDLE:
          if (scan_go)
          begin
            state_q    <= SCAN_CLEAR;
            col_q      <= 4'h0;
            hit_q      <= 1'b0;
            scan_clr_q <= 1'b1; // RL8
          end
        SCAN_CLEAR:
        begin
          scan_clr_q <= 1'b0;
          col_en_q   <= 1'b1;
          dwell_q    <= 12'h000;
          state_q    <= SCAN_DWELL;
        end
        SCAN_DWELL:
          if (dwell_q == 12'(`LLPS_SCAN_DWELL_CYC - 1))
            state_q <= SCAN_SAMPLE;
          else
            dwell_q <= dwell_q + 12'h001;
        SCAN_SAMPLE:
        begin
          col_en_q <= 1'b0;
          if (!sense_n_q && !hit_q)
          begin
            hit_q     <= 1'b1; // RL8
            hit_col_q <= col_q;
          end
          if (scan_done)
            state_q <= SCAN_IDLE;
          else
          begin
            col_q      <= col_q + 4'h1;
            scan_clr_q <= 1'b1; // RL8
            state_q    <= SCAN_CLEAR;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Loop drivers and serial path
  // ----------------------------------------
  // Open-collector style: data always low, enable pulls the line
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      ser_q      <= 1'b1;
      rts_n_q    <= 1'b1;
      trig_oe_q  <= 1'b0;
      rdy_oe_q   <= 1'b1;
      sense_oe_q <= 1'b0;
      clr_oe_q   <= 1'b0;
      oc_low_q   <= 1'b0;
    end
    else
    begin
      rts_n_q    <= follower & ~ctrl_q[`LLPS_CTRL_ANSWER]; // RL11 RL12
      ser_q      <= (SER_TX_DATA_IN & ~rts_n_q) | (s2_q[`LLPS_S_SER] & rts_n_q); // RL10 RL13 RL14
      trig_oe_q  <= ~follower & ctrl_q[`LLPS_CTRL_TRIG]; // RL15 RL16 RL21
      rdy_oe_q   <= ctrl_q[`LLPS_CTRL_BUSY];             // RL17
      sense_oe_q <= ~follower & flag_q;                  // RL3
      clr_oe_q   <= ctrl_q[`LLPS_CTRL_PEN_CLEAR] | scan_clr_q; // RL5
      oc_low_q   <= 1'b0;
    end
  end

  assign LNK.unit_loop_serial_out = ser_q;
  assign LNK.unit_trig_o          = oc_low_q;
  assign LNK.unit_trig_oe         = trig_oe_q;
  assign LNK.unit_rdy_o           = oc_low_q;
  assign LNK.unit_rdy_oe          = rdy_oe_q;
  assign LNK.unit_sense_o         = oc_low_q;
  assign LNK.unit_sense_oe        = sense_oe_q;
  assign LNK.unit_clr_o           = oc_low_q;
  assign LNK.unit_clr_oe          = clr_oe_q;

  // ----------------------------------------
  // APB slave and user outputs
  // ----------------------------------------
  // Read data is latched in setup so the answer comes in the first access cycle
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= PSEL_IN & ~PENABLE_IN;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (PSEL_IN && !PENABLE_IN)
      begin
        case (PADDR_IN)
          `LLPS_CTRL_OFS:   prdata_q <= {27'h0, ctrl_q};
          `LLPS_STAT_OFS:   prdata_q <= {26'h0, rts_n_q, hit_q, state_q != SCAN_IDLE, loop_up_q,
                                         s2_q[`LLPS_S_RDY], sense_n_q};
          `LLPS_EVT_OFS:    prdata_q <= {27'h0, ev_q};
          `LLPS_RESULT_OFS: prdata_q <= {27'h0, hit_q, hit_col_q};
          default:          pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  assign PRDATA_OUT  = prdata_q;
  assign PREADY_OUT  = pready_q;
  assign PSLVERR_OUT = pslverr_q;

  // Registered user outputs
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      SER_RX_DATA_OUT  <= 1'b1;
      SER_RTS_N_OUT    <= 1'b1;
      PEN_SENSE_N_OUT  <= 1'b1;
      IRQ_OUT          <= 1'b0;
      DISP_SUSPEND_OUT <= 1'b0;
      DISP_COL_EN_OUT  <= 1'b0;
      DISP_COL_OUT     <= 4'h0;
    end
    else
    begin
      SER_RX_DATA_OUT  <= s2_q[`LLPS_S_SER];
      SER_RTS_N_OUT    <= rts_n_q;      // RL11
      PEN_SENSE_N_OUT  <= sense_n_q;    // RL2
      IRQ_OUT          <= |ev_q;        // RL6
      DISP_SUSPEND_OUT <= state_q != SCAN_IDLE; // RL7
      DISP_COL_EN_OUT  <= col_en_q;
      DISP_COL_OUT     <= col_q;
    end
  end
endmodule : llps_unit
`default_nettype wire

// >>> bench/llps_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "llps_cfg.svh"
// ----------------------------------------
// Wire checks on the loop between the two ends
// ----------------------------------------
module llps_properties (
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  input wire logic unit_trig_o,
  input wire logic unit_trig_oe,
  input wire logic unit_rdy_o,
  input wire logic unit_rdy_oe,
  input wire logic unit_sense_o,
  input wire logic unit_clr_o,
  input wire logic peer_rdy_oe,
  input wire logic pen_light_pulse_n,
  input wire logic loop_trig_n,
  input wire logic loop_all_ready,
  input wire logic loop_pen_sense_n,
  input wire logic loop_pen_sense_clear_n
);
  localparam int PEN_LO = `LLPS_PEN_PULSE_CYC - 8;
  localparam int PEN_HI = `LLPS_PEN_PULSE_CYC + 8;
  int low_q;

  // Length of the pen pulse so far; a few cycles slack for the pen itself
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN || pen_light_pulse_n)
      low_q <= 0;
    else
      low_q <= low_q + 1;
  end

  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  drain_low_a : assert property (
    !(unit_trig_o | unit_rdy_o | unit_sense_o | unit_clr_o)) else $error("open-collector data not low");
  ready_wired_a : assert property (
    loop_all_ready == !(unit_rdy_oe | peer_rdy_oe)) else $error("all-ready not wired-or");
  ready_reset_a : assert property (
    $past(SRST_IN) |-> unit_rdy_oe) else $error("unit ready right after reset");
  pen_set_a : assert property (
    $rose(pen_light_pulse_n) |-> ##[1:8] !loop_pen_sense_n) else $error("pen flag not set by pulse end");
  pen_stands_a : assert property (
    loop_pen_sense_clear_n[*4] ##0 $rose(pen_light_pulse_n) ##1 loop_pen_sense_clear_n[*8] |=> !loop_pen_sense_n)
    else $error("pen flag lost without clear");
  clear_wins_a : assert property (
    (!loop_pen_sense_clear_n && $stable(pen_light_pulse_n))[*8] |-> loop_pen_sense_n)
    else $error("pen flag survives held clear");
  pen_width_a : assert property (
    $rose(pen_light_pulse_n) |-> (low_q >= PEN_LO && low_q <= PEN_HI)) else $error("pen pulse width off");
  trig_wire_a : assert property (
    loop_trig_n == !unit_trig_oe) else $error("loop trigger not from unit");

  pen_rise_c : cover property ($rose(pen_light_pulse_n));
  ready_c : cover property (loop_all_ready);
  trig_c : cover property (!loop_trig_n);
  clear_c : cover property (!loop_pen_sense_clear_n[*8]);
endmodule : llps_properties
`default_nettype wire

// >>> bench/test_loop_link_and_pen_sense.sv
`timescale 1ns/10ps
`default_nettype none
`include "llps_cfg.svh"
module test_loop_link_and_pen_sense;
  import llps_pkg::*;
  logic       clk, srst, psel, penable, pwrite, btn_n, ext_n, tx, flash, pclr, pbusy, pans, ptx, err;
  logic       pready, pslverr, rx, rts_n, sense_n, irq, susp, col_en, p_rx, p_frst, p_ftrg, p_sn, p_rdy;
  logic [3:0] col;
  llps_addr_t paddr;
  llps_data_t pwdata, prdata, rdat;
  int         bad_count, cmp_count, k, i, m, v, clr_cnt;
  int         seed = 32'h0ac62357;
  bit         q[$];

  // ----------------------------------------
  // Clock, ends and wire checker
  // ----------------------------------------
  initial clk = 1'b0;
  always #20 clk = ~clk;

  llps_if i_llps_if ();
  llps_unit i_llps_unit (.CORE_CLK_IN(clk), .SRST_IN(srst), .LNK(i_llps_if.unit), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PEN_BUTTON_N_IN(btn_n), .EXT_TRIG_N_IN(ext_n),
    .SER_TX_DATA_IN(tx), .SER_RX_DATA_OUT(rx), .SER_RTS_N_OUT(rts_n), .PEN_SENSE_N_OUT(sense_n),
    .IRQ_OUT(irq), .DISP_SUSPEND_OUT(susp), .DISP_COL_EN_OUT(col_en), .DISP_COL_OUT(col));
  llps_peer i_llps_peer (.CORE_CLK_IN(clk), .SRST_IN(srst), .LNK(i_llps_if.peer), .PEN_FLASH_IN(flash),
    .PEN_CLEAR_IN(pclr), .BUSY_IN(pbusy), .ANSWER_IN(pans), .TX_DATA_IN(ptx), .RX_DATA_OUT(p_rx),
    .FOLLOW_RESET_OUT(p_frst), .FOLLOW_TRIG_OUT(p_ftrg), .PEN_SENSE_N_OUT(p_sn), .ALL_READY_OUT(p_rdy));
  llps_properties i_llps_properties (.CORE_CLK_IN(clk), .SRST_IN(srst),
    .unit_trig_o(i_llps_if.unit_trig_o), .unit_trig_oe(i_llps_if.unit_trig_oe),
    .unit_rdy_o(i_llps_if.unit_rdy_o), .unit_rdy_oe(i_llps_if.unit_rdy_oe),
    .unit_sense_o(i_llps_if.unit_sense_o), .unit_clr_o(i_llps_if.unit_clr_o),
    .peer_rdy_oe(i_llps_if.peer_rdy_oe), .pen_light_pulse_n(i_llps_if.pen_light_pulse_n),
    .loop_trig_n(i_llps_if.loop_trig_n), .loop_all_ready(i_llps_if.loop_all_ready),
    .loop_pen_sense_n(i_llps_if.loop_pen_sense_n), .loop_pen_sense_clear_n(i_llps_if.loop_pen_sense_clear_n));

  // Counts clear strobes the unit puts on the loop
  always @(posedge i_llps_if.unit_clr_oe) clr_cnt++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task chk(input string nm, input llps_data_t exp, input llps_data_t got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // A wait that ran out ends the run at once
  task lim(input string nm, input bit ok);
    if (!ok)
    begin
      bad_count++;
      $display("[ERR] %s wait expired", nm);
      stop_test();
    end
  endtask : lim

  // Request held until pready is sampled high at a rising edge, released at that edge
  task apb(input logic w, input llps_addr_t a, input llps_data_t d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20 && !(k > 0 && pready === 1'b1); k++)
      @(posedge clk);
    lim("pready", pready === 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input string nm, input llps_addr_t a, input llps_data_t msk, input llps_data_t exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdat & msk);
  endtask : rd

  task wctl(input int c, input int n);
    apb(1'b1, `LLPS_CTRL_OFS, llps_data_t'(c));
    repeat (n) @(posedge clk);
  endtask : wctl

  task pen;
    @(posedge clk);
    flash <= 1'b1;
    @(posedge clk);
    flash <= 1'b0;
  endtask : pen

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, flash, pclr, pbusy, pans} = '0;
    {btn_n, ext_n, tx, ptx, srst} = '1;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    // Reset state, refused address, ready line
    rd("ctrl reset", `LLPS_CTRL_OFS, 32'h3f, 32'h08);
    chk("ready oe", 1, i_llps_if.unit_rdy_oe);
    chk("rts lead", 0, rts_n);
    rd("unmapped", 8'h10, 32'hffffffff, 32'h0);
    chk("slverr", 1, err);
    wctl(0, 4);
    chk("all ready", 1, i_llps_if.loop_all_ready);
    rd("stat ready", `LLPS_STAT_OFS, 32'h2, 32'h2);
    pbusy <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ready pulled", 0, i_llps_if.loop_all_ready);
    pbusy <= 1'b0;
    // Lead role: controller data one cycle later, queued model
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      v = $random(seed);
      tx <= v[0];
      #1;
      if (i > 0)
        chk("tx gate", q.pop_front(), i_llps_if.unit_loop_serial_out);
      q.push_back(v[0]);
    end
    // Lead, follower, answering follower; neighbour sends the inverse
    pans <= 1'b1;
    for (m = 0; m < 3; m++)
    begin
      wctl((m > 0 ? 1 : 0) + (m == 2 ? 4 : 0), 4);
      chk("rts role", m == 1, rts_n);
      for (v = 0; v < 2; v++)
      begin
        tx <= !v[0];
        ptx <= v[0];
        repeat (12) @(posedge clk);
        chk("loop out", v[0] ^ (m != 1), i_llps_if.unit_loop_serial_out);
        chk("rx in", v, rx);
        chk("peer rx", v[0] ^ (m != 1), p_rx);
      end
    end
    pans <= 1'b0;
    tx <= 1'b1;
    // Pen flag: set at pulse end, cleared locally then from the loop
    wctl(0, 4);
    for (i = 0; i < 2; i++)
    begin
      pen();
      repeat (100) @(posedge clk);
      chk("no early set", 1, sense_n);
      for (k = 0; k < 500 && sense_n !== 1'b0; k++)
        @(posedge clk);
      lim("pen set", sense_n === 1'b0);
      repeat (4) @(posedge clk);
      chk("loop sense", 0, p_sn);
      rd("stat sense", `LLPS_STAT_OFS, 32'h1, 32'h0);
      if (i == 0)
        wctl(2, 10);
      else
        pclr <= 1'b1;
      repeat (10) @(posedge clk);
      chk("clear line", 0, i_llps_if.loop_pen_sense_clear_n);
      wctl(0, 0);
      pclr <= 1'b0;
      repeat (6) @(posedge clk);
      chk("cleared", 1, sense_n);
    end
    // External trigger in lead role, event cleared by write one
    ext_n <= 1'b0;
    repeat (6) @(posedge clk);
    ext_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd("ext evt", `LLPS_EVT_OFS, 32'h2, 32'h2);
    chk("irq", 1, irq);
    apb(1'b1, `LLPS_EVT_OFS, 32'h1f);
    repeat (2) @(posedge clk);
    chk("irq clr", 0, irq);
    // Loop trigger with the ready line true, then false
    for (v = 0; v < 2; v++)
    begin
      pbusy <= v[0];
      repeat (6) @(posedge clk);
      wctl(16, 0);
      for (k = 0; k < 20 && (v ? p_frst : p_ftrg) !== 1'b1; k++)
        @(posedge clk);
      lim("follower event", (v ? p_frst : p_ftrg) === 1'b1);
      chk("peer ready", !v[0], p_rdy);
      chk("trig drive", 0, i_llps_if.loop_trig_n);
      wctl(0, 6);
    end
    pbusy <= 1'b0;
    // Follower ignores the external input and never drives the trigger
    wctl(17, 4);
    chk("follower trig", 1, i_llps_if.loop_trig_n);
    ext_n <= 1'b0;
    repeat (6) @(posedge clk);
    ext_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd("follower evt", `LLPS_EVT_OFS, 32'h2, 32'h0);
    wctl(0, 4);
    // Button scan, pen seen on column five
    apb(1'b1, `LLPS_EVT_OFS, 32'h1f);
    clr_cnt = 0;
    btn_n <= 1'b0;
    repeat (6) @(posedge clk);
    btn_n <= 1'b1;
    for (k = 0; k < 20 && susp !== 1'b1; k++)
      @(posedge clk);
    lim("suspend", susp === 1'b1);
    chk("irq button", 1, irq);
    for (i = 0; i < `LLPS_SCAN_COLS; i++)
    begin
      for (k = 0; k < 3000 && (col_en !== 1'b1 || col !== i[3:0]); k++)
        @(posedge clk);
      lim("column", col_en === 1'b1 && col === i[3:0]);
      chk("clears", i + 1, clr_cnt);
      if (i == 5)
        pen();
    end
    for (k = 0; k < 3000 && susp !== 1'b0; k++)
      @(posedge clk);
    lim("scan end", susp === 1'b0);
    rd("result", `LLPS_RESULT_OFS, 32'h1f, 32'h15);
    rd("events", `LLPS_EVT_OFS, 32'h11, 32'h11);
    stop_test();
  end
endmodule : test_loop_link_and_pen_sense
`default_nettype wire
